// [tcsc_top.sv]
// clock source, pll reference and output data selection with ahb-lite registers
// Contract
// [R1] pll reference is register bit or pin
// [R2] biphase lock: 20 ms plus 384/1 periods
// [R3] word clock lock within 35 ms
// [R4] parallel strap forces quick lock
// [R5] word clock drives master, bit, frame clocks
// [R6] frame clock within 5% of word clock
// [R7] frame clock aligned when both references present
// [R8] host clears aligned bit if not synchronous
// [R9] independent rate splits transmitter clock source
// [R10] mode 0 pll received, mode 1 crystal aux; code outputs 0 instead of aux in mode 1 while indep is set
// [R11] mode 2 falls back to crystal on unlock
// [R12] mode 3 crystal clock, pll keeps running
// [R13] crystal must differ from recovered rate
// [R14] modes 4-6 word clock, crystal, fallback
// [R15] word clock modes output auxiliary data
// [R16] crystal stopped when select is 1,1; code stops it only in clock mode CM_PLL
// [R17] detect ten sampling rates, crystal or status
// [R18] bad preamble interval drops lock
// [R19] unlocked from reset, drives glitchless fallback
`timescale 1ns/1ps
`include "tcsc_params.svh"
module tcsc_top #(
  parameter int SETTLE_CYCLES = `TCSC_SETTLE_MS * 1000 * `TCSC_CLK_MHZ
) (
  input  wire logic            hclk,
  input  wire logic            hresetn,
  input  wire logic            hsel,
  input  wire logic [31:0]     haddr,
  input  wire logic [1:0]      htrans,
  input  wire logic            hwrite,
  input  wire logic [2:0]      hsize,
  input  wire logic [31:0]     hwdata,
  input  wire logic            hready,
  output logic                 hreadyout,
  output logic                 hresp,
  output logic [31:0]          hrdata,
  input  wire logic            power_down_pin_n,
  input  wire logic            pll_ref_select_pin,
  input  wire logic            parallel_mode_strap,
  input  wire logic [7:0]      biphase_inputs,
  input  wire logic            word_clock_input,
  input  wire logic            received_data,
  input  wire logic            auxiliary_serial_in,
  input  wire tcsc_pkg::tcsc_fs_t channel_status_fs,
  output logic [1:0]           master_clock_outputs,
  output logic                 bit_clock,
  output logic                 frame_clock,
  output logic                 serial_data_out,
  output logic                 pll_enable,
  output logic                 crystal_enable,
  output logic                 clock_from_crystal,
  output logic                 tx_clock_from_crystal,
  output logic                 irq
);
  import tcsc_pkg::*;

  localparam logic [12:0] XTAL_PER = `TCSC_XTAL_PERIOD;

  tcsc_lock_if lk ();

  logic [13:0] s1;
  logic [13:0] s2;
  logic [13:0] s3;
  logic [10:0] ctrl;
  logic [2:0]  irq_st;
  logic [2:0]  irq_mask;
  logic        acc_wr;
  logic [4:0]  acc_addr;
  logic [1:0]  init_cnt;
  logic        strap_lat;
  logic        ref_is_wclk;
  logic        ref_chg;
  logic        quick_eff;
  logic        want_xtal;
  logic        sel_rx;
  logic [7:0]  phase;
  logic [4:0]  div;
  logic [4:0]  half;
  logic [12:0] per_sel;
  logic        tick;
  logic        wrap;
  logic        resync;
  tcsc_fs_e    fs_code;
  tcsc_fs_e    next_fs;
  tcsc_cm_e    cm;
  logic [31:0] next_rd;

  wire pdn_ok  = s2[13];
  wire wclk_r  = s2[10] & ~s3[10];
  wire bp_r    = s2[ctrl[10:8]] & ~s3[ctrl[10:8]];
  wire ctrl_ref   = ctrl[0];
  wire ctrl_quick = ctrl[3];
  wire indep      = ctrl[4];
  wire aligned    = ctrl[5];
  wire [1:0] xsel = ctrl[7:6];
  assign cm = tcsc_cm_e'(ctrl[2:1]);

  // pins from outside the clock domain, two flops then edge history
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s1 <= 14'h0;
      s2 <= 14'h0;
      s3 <= 14'h0;
    end else begin
      s1 <= {power_down_pin_n, pll_ref_select_pin, parallel_mode_strap, word_clock_input,
             received_data, auxiliary_serial_in, biphase_inputs};
      s2 <= s1;
      s3 <= s2;
    end
  end

  // strap caught after reset release and while powered down
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      init_cnt  <= 2'h0;
      strap_lat <= 1'b0;
    end else begin
      if (init_cnt != 2'h3) begin
        init_cnt <= init_cnt + 2'd1;
      end
      if (init_cnt != 2'h3 || !pdn_ok) begin
        strap_lat <= s2[11];
      end
    end
  end

  // ahb-lite slave, zero wait states
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  wire take = hready & hsel & htrans[1];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      acc_wr   <= 1'b0;
      acc_addr <= 5'h0;
    end else if (hready) begin
      acc_wr   <= take & hwrite;
      acc_addr <= haddr[4:0];
    end
  end

  always_comb begin
    next_rd = 32'h0;
    case (haddr[4:0])
      `TCSC_A_CTRL: next_rd = {21'h0, ctrl};
      `TCSC_A_STAT: next_rd = {22'h0, quick_eff, crystal_enable, pll_enable, fs_code,
                               ref_is_wclk, clock_from_crystal, !lk.locked};
      `TCSC_A_IRQ:  next_rd = {29'h0, irq_st};
      `TCSC_A_MASK: next_rd = {29'h0, irq_mask};
      `TCSC_A_PER:  next_rd = {19'h0, lk.period};
      default:      next_rd = 32'h0;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0;
    end else if (take && !hwrite) begin
      hrdata <= next_rd;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl     <= `TCSC_CTRL_RST;
      irq_mask <= 3'h0;
    end else if (acc_wr) begin
      if (acc_addr == `TCSC_A_CTRL) begin
        ctrl <= hwdata[10:0]; // [R8]
      end
      if (acc_addr == `TCSC_A_MASK) begin
        irq_mask <= hwdata[2:0];
      end
    end
  end

  // events: lock lost, lock gained, rate changed; set beats clear
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_st <= 3'h0;
    end else begin
      irq_st <= (irq_st & ~((acc_wr && acc_addr == `TCSC_A_IRQ) ? hwdata[2:0] : 3'h0)) |
                {next_fs != fs_code, lk.gained, lk.lost};
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_st & irq_mask);
    end
  end

  // reference and lock detector control
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ref_is_wclk <= 1'b0;
      ref_chg     <= 1'b0;
      quick_eff   <= 1'b0;
    end else begin
      ref_is_wclk <= ctrl_ref | s2[12]; // [R1]
      ref_chg     <= ref_is_wclk != (ctrl_ref | s2[12]);
      quick_eff   <= ctrl_quick | strap_lat; // [R4]
    end
  end

  assign lk.ref_event = ref_is_wclk ? wclk_r : bp_r; // [R5]
  assign lk.clear     = !pdn_ok || !pll_enable || ref_chg;
  assign lk.need_good = (ref_is_wclk || quick_eff) ? `TCSC_GOOD_FAST : `TCSC_GOOD_SLOW; // [R2] [R3]

  tcsc_lock_det #(
    .SETTLE_CYCLES (SETTLE_CYCLES)
  ) u_lock (
    .hclk    (hclk),
    .hresetn (hresetn),
    .lk      (lk)
  );

  // mode decode
  always_comb begin
    case (cm)
      CM_PLL:      want_xtal = 1'b0;                  // [R10] [R14]
      CM_XTAL:     want_xtal = 1'b1;                  // [R10] [R14]
      CM_FALLBACK: want_xtal = !lk.locked;            // [R11] [R14] [R19]
      CM_XTAL_MON: want_xtal = 1'b1;                  // [R12]
      default:     want_xtal = 1'b1;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pll_enable     <= 1'b0;
      crystal_enable <= 1'b1;
      sel_rx         <= 1'b0;
    end else begin
      pll_enable     <= pdn_ok && (cm != CM_XTAL);                    // [R10] [R12]
      crystal_enable <= !(cm == CM_PLL && xsel == 2'b11);             // [R16]
      sel_rx         <= !ref_is_wclk && !want_xtal;                   // [R15]
    end
  end

  // source switches at a frame boundary, or at once while powered down, so clocks never glitch
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      clock_from_crystal <= 1'b1;
    end else if (!pdn_ok || wrap) begin
      clock_from_crystal <= !pdn_ok || want_xtal; // [R19]
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tx_clock_from_crystal <= 1'b1;
    end else begin
      tx_clock_from_crystal <= indep | clock_from_crystal; // [R9]
    end
  end

  // 256 ticks per frame: 128fs, 64fs and 1fs from one counter; tick length rounded to nearest
  assign per_sel = clock_from_crystal ? XTAL_PER : lk.period;
  assign half    = per_sel[12:8] + {4'h0, per_sel[7]};
  assign tick   = (half == 5'h0) || (div >= half - 5'd1);
  assign wrap   = tick && (phase == 8'hff);
  assign resync = wclk_r && lk.locked && !clock_from_crystal && (ref_is_wclk || aligned); // [R6] [R7]

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      div   <= 5'h0;
      phase <= 8'h0;
    end else if (!pdn_ok || resync) begin
      div   <= 5'h0;
      phase <= 8'h0;
    end else if (tick) begin
      div   <= 5'h0;
      phase <= phase + 8'd1;
    end else begin
      div <= div + 5'd1;
    end
  end

  assign master_clock_outputs = {phase[1], phase[0]}; // [R5]
  assign bit_clock            = phase[1];
  assign frame_clock          = phase[7];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      serial_data_out <= 1'b0;
    end else if (sel_rx) begin
      serial_data_out <= s2[9];
    end else begin
      serial_data_out <= (indep && !ref_is_wclk) ? 1'b0 : s2[8]; // [R15] [R9]
    end
  end

  // rate from the measured period, or from channel status when the crystal select is 1,1
  always_comb begin
    if (xsel == 2'b11) begin
      next_fs = tcsc_fs_e'(channel_status_fs);
    end else if (!lk.locked) begin
      next_fs = FS_NONE;
    end else if (lk.period > `TCSC_TH_22K05) begin
      next_fs = FS_22K05;
    end else if (lk.period > `TCSC_TH_24K) begin
      next_fs = FS_24K;
    end else if (lk.period > `TCSC_TH_32K) begin
      next_fs = FS_32K;
    end else if (lk.period > `TCSC_TH_44K1) begin
      next_fs = FS_44K1;
    end else if (lk.period > `TCSC_TH_48K) begin
      next_fs = FS_48K;
    end else if (lk.period > `TCSC_TH_64K) begin
      next_fs = FS_64K;
    end else if (lk.period > `TCSC_TH_88K2) begin
      next_fs = FS_88K2;
    end else if (lk.period > `TCSC_TH_96K) begin
      next_fs = FS_96K;
    end else if (lk.period > `TCSC_TH_176K4) begin
      next_fs = FS_176K4;
    end else begin
      next_fs = FS_192K;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fs_code <= FS_NONE;
    end else begin
      fs_code <= next_fs; // [R17]
    end
  end

  property p_ref_or;
    @(posedge hclk) disable iff (!hresetn) ##1 ref_is_wclk == $past(ctrl_ref | s2[12]);
  endproperty
  a_ref_or: assert property (p_ref_or) else $error("reference select not the or"); // [R1]

  property p_quick;
    @(posedge hclk) disable iff (!hresetn) strap_lat |=> quick_eff;
  endproperty
  a_quick: assert property (p_quick) else $error("strap did not force quick lock"); // [R4]

  property p_mode1_off;
    @(posedge hclk) disable iff (!hresetn) (cm == CM_XTAL) |=> !pll_enable;
  endproperty
  a_mode1_off: assert property (p_mode1_off) else $error("pll running in crystal mode"); // [R10]

  property p_mode3_on;
    @(posedge hclk) disable iff (!hresetn) (cm == CM_XTAL_MON && pdn_ok) |=> pll_enable;
  endproperty
  a_mode3_on: assert property (p_mode3_on) else $error("pll stopped in monitor mode"); // [R12]

  property p_fallback;
    @(posedge hclk) disable iff (!hresetn) (cm == CM_FALLBACK && !lk.locked && wrap) |=> clock_from_crystal;
  endproperty
  a_fallback: assert property (p_fallback) else $error("no crystal fallback on unlock"); // [R11]

  property p_wclk_aux;
    @(posedge hclk) disable iff (!hresetn) ref_is_wclk |=> !sel_rx;
  endproperty
  a_wclk_aux: assert property (p_wclk_aux) else $error("received data in word clock mode"); // [R15]

  property p_xtal_off;
    @(posedge hclk) disable iff (!hresetn) (cm == CM_PLL && xsel == 2'b11) |=> !crystal_enable;
  endproperty
  a_xtal_off: assert property (p_xtal_off) else $error("crystal not stopped"); // [R16]

  property p_sync_tx;
    @(posedge hclk) disable iff (!hresetn) !indep |=> tx_clock_from_crystal == $past(clock_from_crystal);
  endproperty
  a_sync_tx: assert property (p_sync_tx) else $error("transmitter source differs"); // [R9]

  property p_resync;
    @(posedge hclk) disable iff (!hresetn) resync && pdn_ok |=> phase == 8'h0 && !frame_clock;
  endproperty
  a_resync: assert property (p_resync) else $error("frame clock not realigned"); // [R6]

  c_fallback: cover property (@(posedge hclk) disable iff (!hresetn) cm == CM_FALLBACK && $rose(clock_from_crystal));
  c_resync: cover property (@(posedge hclk) disable iff (!hresetn) resync);
  c_irq: cover property (@(posedge hclk) disable iff (!hresetn) $rose(irq));
endmodule // tcsc_top

// [tcsc_params.svh]
// constants for the transceiver clock source control block
`ifndef TCSC_PARAMS_SVH
`define TCSC_PARAMS_SVH
`define TCSC_CLK_MHZ 100
`define TCSC_SETTLE_MS 20
`define TCSC_WCLK_LOCK_MS 35
`define TCSC_GOOD_SLOW 9'd384
`define TCSC_GOOD_FAST 9'd1
`define TCSC_MIN_PERIOD 13'd463
`define TCSC_MAX_PERIOD 13'd4545
`define TCSC_TIMEOUT 13'd4546
`define TCSC_TOL 13'd4
`define TCSC_XTAL_PERIOD 13'd2083
`define TCSC_A_CTRL 5'h00
`define TCSC_A_STAT 5'h04
`define TCSC_A_IRQ 5'h08
`define TCSC_A_MASK 5'h0c
`define TCSC_A_PER 5'h10
`define TCSC_CTRL_RST 11'h000
`define TCSC_TH_22K05 13'd4351
`define TCSC_TH_24K 13'd3646
`define TCSC_TH_32K 13'd2696
`define TCSC_TH_44K1 13'd2175
`define TCSC_TH_48K 13'd1823
`define TCSC_TH_64K 13'd1348
`define TCSC_TH_88K2 13'd1088
`define TCSC_TH_96K 13'd804
`define TCSC_TH_176K4 13'd544
`endif

// [tcsc_pkg.sv]
// types for the transceiver clock source control block
package tcsc_pkg;
  typedef logic [3:0] tcsc_fs_t;
  typedef enum logic [3:0] {
    FS_NONE = 4'b0000, FS_22K05 = 4'b0001, FS_24K = 4'b0010, FS_32K = 4'b0011,
    FS_44K1 = 4'b0100, FS_48K = 4'b0101, FS_64K = 4'b0110, FS_88K2 = 4'b0111,
    FS_96K = 4'b1000, FS_176K4 = 4'b1001, FS_192K = 4'b1010
  } tcsc_fs_e;
  typedef enum logic [1:0] {
    CM_PLL = 2'b00, CM_XTAL = 2'b01, CM_FALLBACK = 2'b10, CM_XTAL_MON = 2'b11
  } tcsc_cm_e;
endpackage

// [tcsc_lock_if.sv]
// signals between the clock control and the lock detector
`timescale 1ns/1ps
interface tcsc_lock_if;
  logic        ref_event;
  logic        clear;
  logic [8:0]  need_good;
  logic        locked;
  logic [12:0] period;
  logic        lost;
  logic        gained;
  modport det (input ref_event, clear, need_good, output locked, period, lost, gained);
  modport ctl (output ref_event, clear, need_good, input locked, period, lost, gained);
endinterface

// [tcsc_lock_det.sv]
// reference interval checker that models pll lock and loss of lock
`timescale 1ns/1ps
`include "tcsc_params.svh"
module tcsc_lock_det #(
  parameter int SETTLE_CYCLES = 2000000
) (
  input wire logic   hclk,
  input wire logic   hresetn,
  tcsc_lock_if.det   lk
);
  import tcsc_pkg::*;
  logic [12:0] cnt;
  logic [20:0] settle;
  logic [8:0]  good;
  logic        seen;
  logic        bad;
  logic        tmo;
  logic        done;
  logic        lose;
  logic        gain;

  assign tmo  = (cnt == `TCSC_TIMEOUT);
  assign done = (settle == SETTLE_CYCLES[20:0]);
  // interval outside range or jumping against the last one
  assign bad  = (cnt < `TCSC_MIN_PERIOD) || (cnt > `TCSC_MAX_PERIOD) ||
                (seen && ((cnt > lk.period + `TCSC_TOL) || (cnt + `TCSC_TOL < lk.period)));
  assign lose = lk.locked && ((lk.ref_event && bad) || tmo); // [R18]
  // compared one bit wider so a saturated count still reaches the target
  assign gain = !lk.locked && done && lk.ref_event && !bad &&
                ({1'b0, good} + 10'd1 >= {1'b0, lk.need_good}); // [R2] [R3]

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt <= 13'h0;
    end else if (lk.clear || lk.ref_event) begin
      cnt <= 13'h0;
    end else if (!tmo) begin
      cnt <= cnt + 13'd1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      lk.period <= 13'h0;
      seen      <= 1'b0;
    end else if (lk.clear) begin
      seen <= 1'b0;
    end else if (lk.ref_event) begin
      lk.period <= cnt;
      seen      <= 1'b1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      settle <= 21'h0;
    end else if (lk.clear || lose) begin
      settle <= 21'h0;
    end else if (!done) begin
      settle <= settle + 21'd1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      good <= 9'h0;
    end else if (lk.clear || tmo || (lk.ref_event && bad)) begin
      good <= 9'h0;
    end else if (lk.ref_event && good != 9'h1ff) begin
      good <= good + 9'd1;
    end
  end

  // unlocked from reset until the first lock
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      lk.locked <= 1'b0;
      lk.lost   <= 1'b0;
      lk.gained <= 1'b0;
    end else begin
      lk.locked <= !lk.clear && (gain || (lk.locked && !lose)); // [R19]
      lk.lost   <= lose && !lk.clear;
      lk.gained <= gain && !lk.clear;
    end
  end

  property p_unlock_bad;
    @(posedge hclk) disable iff (!hresetn) (lk.locked && lk.ref_event && bad) |=> !lk.locked;
  endproperty
  a_unlock_bad: assert property (p_unlock_bad) else $error("lock kept after bad interval"); // [R18]

  property p_lock_count;
    @(posedge hclk) disable iff (!hresetn)
      $rose(lk.locked) |-> $past(done) && ({1'b0, $past(good)} + 10'd1 >= {1'b0, $past(lk.need_good)});
  endproperty
  a_lock_count: assert property (p_lock_count) else $error("lock before settle and good intervals"); // [R2]

  c_lock: cover property (@(posedge hclk) disable iff (!hresetn) $rose(lk.locked));
endmodule // tcsc_lock_det

// [tcsc_src.sv]
// behavioural audio source: biphase frame markers and word clock
`timescale 1ns/1ps
module tcsc_src (
  input  wire logic        hclk,
  input  wire logic        run,
  input  wire logic [12:0] period,
  input  wire logic        glitch,
  output logic [7:0]       biphase_inputs,
  output logic             word_clock_input
);
  logic [12:0] cnt;
  logic [12:0] lim;

  // short intervals only while the bench asks for them
  assign lim = glitch ? (period >> 1) : period;

  initial begin
    cnt = '0;
    biphase_inputs = '0;
    word_clock_input = 1'b0;
  end

  // frame rate kept apart from the crystal rate
  always @(posedge hclk) begin
    if (run) begin
      cnt <= (cnt >= lim - 13'd1) ? 13'd0 : cnt + 13'd1;
      biphase_inputs <= {8{cnt < 13'd8}};
      word_clock_input <= (cnt < (period >> 1));
    end
  end
endmodule // tcsc_src

// [transceiver_clock_source_control_tb.sv]
// self-checking bench for the clock source control block
`timescale 1ns/1ps
`include "tcsc_params.svh"
module transceiver_clock_source_control_tb;
  import tcsc_pkg::*;
  localparam int LIMIT = 100000;
  logic        hclk, hresetn, hsel, hwrite, hready, hresp, irq;
  logic [31:0] haddr, hwdata, hrdata, rdv;
  logic [1:0]  htrans, mco;
  logic [2:0]  hsize;
  logic        pdn_n, ref_pin, strap, rx_data, aux, run, glitch;
  logic [7:0]  bip;
  logic        wclk, bclk, fclk, sdo, pll_en, xtal_en, cfc, tx_cfc, fclk_q, bclk_q, mco0_q;
  tcsc_fs_t    cs_fs;
  tcsc_fs_e    codes [3];
  int          n_fail, n_tests, cyc, i, d, k;

  tcsc_top #(.SETTLE_CYCLES(200)) tcsc_top_inst (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hready),
    .hresp(hresp), .hrdata(hrdata), .power_down_pin_n(pdn_n), .pll_ref_select_pin(ref_pin),
    .parallel_mode_strap(strap), .biphase_inputs(bip), .word_clock_input(wclk),
    .received_data(rx_data), .auxiliary_serial_in(aux), .channel_status_fs(cs_fs),
    .master_clock_outputs(mco), .bit_clock(bclk), .frame_clock(fclk), .serial_data_out(sdo),
    .pll_enable(pll_en), .crystal_enable(xtal_en), .clock_from_crystal(cfc),
    .tx_clock_from_crystal(tx_cfc), .irq(irq));

  tcsc_src tcsc_src_inst (
    .hclk(hclk), .run(run), .period(13'd500), .glitch(glitch),
    .biphase_inputs(bip), .word_clock_input(wclk));

  initial begin
    hclk = 1'b0;
    cyc = 0;
  end
  always #5 hclk = ~hclk;

  always @(posedge hclk) begin
    fclk_q <= fclk;
    bclk_q <= bclk;
    mco0_q <= mco[0];
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      n_fail++;
      summarize();
    end
  end

  task automatic summarize();
    if (n_fail == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // one single ahb-lite transfer, entered just after a rising edge
  task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] wd);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= a;
    hwrite <= wr;
    do @(posedge hclk); while (hready !== 1'b1);
    htrans <= 2'b00;
    hsel <= 1'b0;
    hwdata <= wd;
    do @(posedge hclk); while (hready !== 1'b1);
    rdv = hrdata;
  endtask

  task automatic rdc(input logic [31:0] a, input logic [31:0] m, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    cmp(rdv & m, e);
  endtask

  task automatic poll(input logic [31:0] a, input logic [31:0] m, input logic [31:0] e);
    for (i = 0; i < 4000; i++) begin
      xfer(1'b0, a, 32'h0);
      if ((rdv & m) === e) break;
    end
    cmp(rdv & m, e);
  endtask

  function automatic logic [31:0] cv(input logic [1:0] m, input logic q, input logic [1:0] x);
    return {24'h0, x, 2'b00, q, m, 1'b0};
  endfunction

  initial begin
    n_fail = 0;
    n_tests = 0;
    hresetn = 1'b0;
    {hsel, hwrite, glitch, run, ref_pin, strap, aux} = '0;
    haddr = '0;
    hwdata = '0;
    htrans = 2'b00;
    hsize = 3'b010;
    pdn_n = 1'b1;
    rx_data = 1'b1;
    cs_fs = FS_NONE;
    codes = '{FS_44K1, FS_48K, FS_192K};
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rdc(`TCSC_A_CTRL, 32'h7ff, 32'h0);
    rdc(`TCSC_A_STAT, 32'h3, 32'h3);
    xfer(1'b1, 32'h14, 32'hffffffff);
    rdc(32'h14, 32'hffffffff, 32'h0);
    // biphase reference, quick lock
    wr_ctrl: begin
      xfer(1'b1, `TCSC_A_CTRL, cv(2'd0, 1'b1, 2'd0));
    end
    run <= 1'b1;
    d = cyc;
    poll(`TCSC_A_STAT, 32'h1, 32'h0);
    cmp(cyc - d <= 2000, 1);
    cmp({hready, hresp}, 2'b10);
    rdc(`TCSC_A_STAT, 32'h78, {25'h0, FS_192K, 3'b000});
    rdc(`TCSC_A_IRQ, 32'h2, 32'h2);
    xfer(1'b1, `TCSC_A_MASK, 32'h0);
    rdc(`TCSC_A_MASK, 32'h7, 32'h0);
    cmp(irq, 1'b0);
    xfer(1'b1, `TCSC_A_MASK, 32'h2);
    rdc(`TCSC_A_MASK, 32'h7, 32'h2);
    cmp(irq, 1'b1);
    xfer(1'b1, `TCSC_A_IRQ, 32'h2);
    rdc(`TCSC_A_IRQ, 32'h2, 32'h0);
    cmp(irq, 1'b0);
    poll(`TCSC_A_STAT, 32'h2, 32'h0);
    cmp(sdo, rx_data);
    cmp(tx_cfc, cfc);
    // both sources share one timebase, so the aligned bit may be set
    xfer(1'b1, `TCSC_A_CTRL, cv(2'd0, 1'b1, 2'd0) | 32'h20);
    do @(posedge hclk); while (wclk !== 1'b0);
    do @(posedge hclk); while (wclk !== 1'b1);
    for (d = 0; d < 600 && !(fclk_q === 1'b1 && fclk === 1'b0); d++) @(posedge hclk);
    cmp((d <= 25) || (d >= 475), 1);
    // channel status rates with crystal stopped
    xfer(1'b1, `TCSC_A_CTRL, cv(2'd0, 1'b1, 2'd3));
    for (k = 0; k < 3; k++) begin
      cs_fs <= codes[k];
      poll(`TCSC_A_STAT, 32'h78, {25'h0, codes[k], 3'b000});
    end
    rdc(`TCSC_A_IRQ, 32'h4, 32'h4);
    cmp(xtal_en, 1'b0);
    xfer(1'b1, `TCSC_A_CTRL, cv(2'd0, 1'b1, 2'd0) | 32'h10);
    repeat (4) @(posedge hclk);
    cmp(tx_cfc, 1'b1);
    // mode 2: fallback on bad interval, back after relock
    aux <= 1'b1;
    rx_data <= 1'b0;
    xfer(1'b1, `TCSC_A_CTRL, cv(2'd2, 1'b1, 2'd0));
    glitch <= 1'b1;
    poll(`TCSC_A_STAT, 32'h1, 32'h1);
    glitch <= 1'b0;
    poll(`TCSC_A_STAT, 32'h2, 32'h2);
    cmp(sdo, aux);
    poll(`TCSC_A_STAT, 32'h3, 32'h0);
    repeat (4) @(posedge hclk);
    cmp(sdo, rx_data);
    xfer(1'b1, `TCSC_A_CTRL, cv(2'd1, 1'b1, 2'd0));
    poll(`TCSC_A_STAT, 32'h182, 32'h102);
    cmp(sdo, aux);
    xfer(1'b1, `TCSC_A_CTRL, cv(2'd3, 1'b1, 2'd0));
    poll(`TCSC_A_STAT, 32'h182, 32'h182);
    cmp(sdo, aux);
    // word clock reference through the pin
    ref_pin <= 1'b1;
    xfer(1'b1, `TCSC_A_CTRL, cv(2'd0, 1'b0, 2'd0));
    poll(`TCSC_A_STAT, 32'h7, 32'h4);
    repeat (4) @(posedge hclk);
    cmp(sdo, aux);
    do @(posedge hclk); while (wclk !== 1'b0);
    do @(posedge hclk); while (wclk !== 1'b1);
    for (d = 0; d < 600 && !(fclk_q === 1'b1 && fclk === 1'b0); d++) @(posedge hclk);
    cmp((d <= 25) || (d >= 475), 1);
    @(posedge hclk);
    i = 0;
    for (k = 0, d = 0; d < 600 && !(fclk_q === 1'b1 && fclk === 1'b0); d++) begin
      if (bclk_q === 1'b0 && bclk === 1'b1) k++;
      if (mco0_q === 1'b0 && mco[0] === 1'b1) i++;
      @(posedge hclk);
    end
    // 500-cycle word clock at two cycles a tick: 250 ticks a frame
    cmp(k, 62);
    cmp(i, 125);
    xfer(1'b1, `TCSC_A_CTRL, cv(2'd1, 1'b0, 2'd0));
    poll(`TCSC_A_STAT, 32'h186, 32'h106);
    xfer(1'b1, `TCSC_A_CTRL, cv(2'd2, 1'b0, 2'd0));
    poll(`TCSC_A_STAT, 32'h3, 32'h0);
    run <= 1'b0;
    poll(`TCSC_A_STAT, 32'h3, 32'h3);
    cmp(sdo, aux);
    // power-down with the parallel strap
    ref_pin <= 1'b0;
    run <= 1'b1;
    xfer(1'b1, `TCSC_A_CTRL, cv(2'd0, 1'b0, 2'd0));
    rdc(`TCSC_A_STAT, 32'h200, 32'h0);
    strap <= 1'b1;
    pdn_n <= 1'b0;
    repeat (8) @(posedge hclk);
    cmp(cfc, 1'b1);
    pdn_n <= 1'b1;
    repeat (4) @(posedge hclk);
    rdc(`TCSC_A_STAT, 32'h201, 32'h201);
    summarize();
  end
endmodule // transceiver_clock_source_control_tb
